// *** core/sprd_decode.sv ***
// Stack push/pop, prefix and rotate-through-carry decode and timing
module sprd_decode (
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire sprd_pkg::sprd_byte_t byte_i,
   input wire logic prot_mode_i,
   input wire logic default32_i,
   input wire logic [11:0] stack_flags_i,
   input wire logic [7:0] count_register_i,
   output logic ready_o,
   output sprd_pkg::sprd_issue_t issue_o,
   output logic issue_valid_o,
   output logic done_o,
   output logic bus_lock_o,
   output logic [11:0] flags_o,
   output logic overflow_undef_o
);
   import sprd_pkg::*;

   typedef enum logic [2:0] {SPRD_S_OPC, SPRD_S_ESC, SPRD_S_MODRM, SPRD_S_EXEC} sprd_state_t;

   function automatic logic match(input logic [7:0] b, input logic [7:0] m, input logic [7:0] v);
      return (b & m) == v;
   endfunction

   function automatic logic [1:0] full_imm(input logic o32);
      return o32 ? IMM_DWORD : IMM_WORD;
   endfunction

   sprd_state_t state, next_state;
   sprd_issue_t cur, next_cur;
   logic [7:0] opc, next_opc;
   logic [3:0] cnt, next_cnt;
   logic [11:0] flags, next_flags;
   logic lock, next_lock;
   logic done, next_done;
   logic ivalid, next_ivalid;
   logic ovu, next_ovu;
   logic ready, next_ready;
   // Prefix state kept apart so the issued word stands until the next decode
   logic pfx_lock, next_pfx_lock;
   logic pfx_a32, next_pfx_a32;
   logic pfx_o32, next_pfx_o32;

   // Rotate result: carry takes top bit of operand, overflow is operand bit 6 xor carry
   logic rot_cf;
   assign rot_cf = count_register_i[7];

   always_comb begin
      next_state = state;
      next_cur = cur;
      next_opc = opc;
      next_cnt = cnt;
      next_flags = flags;
      next_lock = lock;
      next_done = 1'b0;
      next_ivalid = 1'b0;
      next_ovu = ovu;
      next_ready = ready;
      next_pfx_lock = pfx_lock;
      next_pfx_a32 = pfx_a32;
      next_pfx_o32 = pfx_o32;
      unique case (state)
         SPRD_S_OPC: begin
            next_lock = 1'b0;
            if (byte_i.valid) begin
               next_opc = byte_i.data;
               next_cur.op = SPRD_OP_NONE;
               next_cur.imm_size = IMM_NONE;
               next_cur.cycles = CYC_ONE;
               next_cur.lock = pfx_lock;
               next_cur.addr32 = pfx_a32;
               next_cur.opnd32 = pfx_o32;
               if (byte_i.data == PFX_LOCK) begin
                  next_pfx_lock = 1'b1;
                  next_cur.lock = 1'b1;
               end else if (byte_i.data == PFX_ADDR) begin
                  next_pfx_a32 = ~pfx_a32;
                  next_cur.addr32 = ~pfx_a32;
               end else if (byte_i.data == PFX_OPND) begin
                  next_pfx_o32 = ~pfx_o32;
                  next_cur.opnd32 = ~pfx_o32;
               end else if (byte_i.data == OP_ESC) begin
                  next_state = SPRD_S_ESC;
               end else if (byte_i.data == OP_POP_RM || byte_i.data == OP_PUSH_RM ||
                            match(byte_i.data, ROT1_MASK, ROT1_OP) ||
                            match(byte_i.data, ROT1_MASK, ROTC_OP) ||
                            match(byte_i.data, ROT1_MASK, ROTI_OP)) begin
                  next_state = SPRD_S_MODRM;
               end else begin
                  next_state = SPRD_S_EXEC;
                  if (byte_i.data == OP_POP_ALL) begin
                     next_cur.op = SPRD_OP_POP_ALL;
                     next_cur.cycles = CYC_ALL;
                  end else if (byte_i.data == OP_POP_FLAGS) begin
                     next_cur.op = SPRD_OP_POP_FLAGS;
                     next_cur.cycles = CYC_FLAGS_POP;
                  end else if (byte_i.data == OP_PUSH_ALL) begin
                     next_cur.op = SPRD_OP_PUSH_ALL;
                     next_cur.cycles = CYC_ALL;
                  end else if (byte_i.data == OP_PUSH_FLAGS) begin
                     next_cur.op = SPRD_OP_PUSH_FLAGS;
                     next_cur.cycles = CYC_TWO;
                  end else if (match(byte_i.data, SEG_MASK, SEG_PUSH)) begin
                     next_cur.op = SPRD_OP_PUSH_SEG;
                  end else if (match(byte_i.data, SEG_MASK, SEG_POP)) begin
                     next_cur.op = SPRD_OP_POP_SEG;
                     next_cur.cycles = prot_mode_i ? CYC_SEG_PROT : CYC_ONE;
                  end else if (match(byte_i.data, SHORT_MASK, PUSH_REG_BASE)) begin
                     next_cur.op = SPRD_OP_PUSH_REG;
                  end else if (match(byte_i.data, SHORT_MASK, POP_REG_BASE)) begin
                     next_cur.op = SPRD_OP_POP_REG;
                  end else if (match(byte_i.data, PUSH_IMM_MASK, PUSH_IMM_OP)) begin
                     next_cur.op = SPRD_OP_PUSH_IMM;
                     // 6A takes a byte, 68 a full-width value
                     next_cur.imm_size = byte_i.data[1] ? IMM_BYTE : full_imm(pfx_o32);
                  end else begin
                     next_state = SPRD_S_OPC;
                  end
               end
            end
         end
         SPRD_S_ESC: begin
            if (byte_i.valid) begin
               next_state = SPRD_S_EXEC;
               next_cur.cycles = CYC_ONE;
               if (match(byte_i.data, SEG3_MASK, SEG3_PUSH)) begin
                  next_cur.op = SPRD_OP_PUSH_SEG;
               end else if (match(byte_i.data, SEG3_MASK, SEG3_POP)) begin
                  next_cur.op = SPRD_OP_POP_SEG;
                  next_cur.cycles = prot_mode_i ? CYC_SEG_PROT : CYC_ONE;
               end else begin
                  next_state = SPRD_S_OPC;
               end
            end
         end
         SPRD_S_MODRM: begin
            if (byte_i.valid) begin
               next_state = SPRD_S_EXEC;
               next_cur.cycles = CYC_ONE;
               if (opc == OP_POP_RM && byte_i.data[5:3] == REG_POP) begin
                  next_cur.op = SPRD_OP_POP_RM;
               end else if (opc == OP_PUSH_RM && byte_i.data[5:3] == REG_PUSH) begin
                  next_cur.op = SPRD_OP_PUSH_RM;
               end else if (byte_i.data[5:3] == REG_RCL && opc[7:1] != OP_POP_RM[7:1]
                            && opc != OP_PUSH_RM) begin
                  next_cur.op = SPRD_OP_RCL;
                  if (match(opc, ROT1_MASK, ROT1_OP)) begin
                     next_cur.cycles = (byte_i.data[7:6] == MOD_REG) ? CYC_RCL_REG
                                                                    : CYC_RCL_MEM;
                  end else begin
                     next_cur.cycles = CYC_RCL_CNT;
                     if (match(opc, ROT1_MASK, ROTI_OP)) begin
                        next_cur.imm_size = IMM_BYTE;
                     end
                  end
               end else begin
                  next_state = SPRD_S_OPC;
               end
            end
         end
         SPRD_S_EXEC: begin
            if (cnt == 4'd0) begin
               next_cnt = cur.cycles - CYC_ONE;
               next_ivalid = 1'b1;
               next_ready = 1'b0;
               next_lock = cur.lock;
            end else begin
               next_cnt = cnt - CYC_ONE;
            end
            if (cnt == CYC_ONE || (cnt == 4'd0 && cur.cycles == CYC_ONE)) begin
               next_done = 1'b1;
               next_state = SPRD_S_OPC;
               next_ready = 1'b1;
               next_cnt = 4'd0;
               // Lock stays up through the done cycle, dropped back in decode
               next_pfx_lock = 1'b0;
               next_pfx_a32 = default32_i;
               next_pfx_o32 = default32_i;
               unique case (cur.op)
                  SPRD_OP_POP_FLAGS: begin
                     next_flags = stack_flags_i & FLAGS_WRITABLE;
                  end
                  SPRD_OP_RCL: begin
                     next_flags[F_CF] = rot_cf;
                     next_flags[F_OF] = count_register_i[6] ^ rot_cf;
                     next_ovu = (cur.cycles == CYC_RCL_CNT) && (opc[7:1] != ROT1_OP[7:1]);
                  end
                  default: begin
                     next_flags = flags;
                  end
               endcase
            end
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state <= SPRD_S_OPC;
         cur <= '0;
         opc <= 8'h00;
         cnt <= 4'h0;
         flags <= 12'h000;
         lock <= 1'b0;
         done <= 1'b0;
         ivalid <= 1'b0;
         ovu <= 1'b0;
         ready <= 1'b1;
         pfx_lock <= 1'b0;
         pfx_a32 <= 1'b0;
         pfx_o32 <= 1'b0;
      end else begin
         state <= next_state;
         cur <= next_cur;
         opc <= next_opc;
         cnt <= next_cnt;
         flags <= next_flags;
         lock <= next_lock;
         done <= next_done;
         ivalid <= next_ivalid;
         ovu <= next_ovu;
         ready <= next_ready;
         pfx_lock <= next_pfx_lock;
         pfx_a32 <= next_pfx_a32;
         pfx_o32 <= next_pfx_o32;
      end
   end

   assign issue_o = cur;
   assign issue_valid_o = ivalid;
   assign done_o = done;
   assign bus_lock_o = lock;
   assign flags_o = flags;
   assign overflow_undef_o = ovu;
   assign ready_o = ready;
endmodule

// *** core/sprd_pkg.sv ***
// Package for the stack, prefix and rotate decode block
package sprd_pkg;
   localparam logic [7:0] OP_POP_RM = 8'h8F;
   localparam logic [7:0] OP_POP_ALL = 8'h61;
   localparam logic [7:0] OP_POP_FLAGS = 8'h9D;
   localparam logic [7:0] OP_PUSH_RM = 8'hFF;
   localparam logic [7:0] OP_PUSH_ALL = 8'h60;
   localparam logic [7:0] OP_PUSH_FLAGS = 8'h9C;
   localparam logic [7:0] PFX_LOCK = 8'hF0;
   localparam logic [7:0] PFX_ADDR = 8'h67;
   localparam logic [7:0] PFX_OPND = 8'h66;
   localparam logic [7:0] OP_ESC = 8'h0F;
   localparam logic [2:0] REG_POP = 3'h0;
   localparam logic [2:0] REG_PUSH = 3'h6;
   localparam logic [2:0] REG_RCL = 3'h2;
   localparam logic [1:0] MOD_REG = 2'h3;
   // Short-form masks: one-byte segment push/pop is 000 sreg2 11x
   localparam logic [7:0] SEG_MASK = 8'hE7;
   localparam logic [7:0] SEG_PUSH = 8'h06;
   localparam logic [7:0] SEG_POP = 8'h07;
   localparam logic [7:0] SEG3_MASK = 8'hC7;
   localparam logic [7:0] SEG3_PUSH = 8'h80;
   localparam logic [7:0] SEG3_POP = 8'h81;
   localparam logic [7:0] PUSH_REG_BASE = 8'h50;
   localparam logic [7:0] POP_REG_BASE = 8'h58;
   localparam logic [7:0] SHORT_MASK = 8'hF8;
   localparam logic [7:0] ROT1_MASK = 8'hFE;
   localparam logic [7:0] ROT1_OP = 8'hD0;
   localparam logic [7:0] ROTC_OP = 8'hD2;
   localparam logic [7:0] ROTI_OP = 8'hC0;
   localparam logic [7:0] PUSH_IMM_MASK = 8'hFD;
   localparam logic [7:0] PUSH_IMM_OP = 8'h68;
   localparam logic [3:0] CYC_ONE = 4'd1;
   localparam logic [3:0] CYC_TWO = 4'd2;
   localparam logic [3:0] CYC_SEG_PROT = 4'd3;
   localparam logic [3:0] CYC_ALL = 4'd6;
   localparam logic [3:0] CYC_FLAGS_POP = 4'd9;
   localparam logic [3:0] CYC_RCL_REG = 4'd3;
   localparam logic [3:0] CYC_RCL_MEM = 4'd8;
   localparam logic [3:0] CYC_RCL_CNT = 4'd8;
   localparam logic [1:0] IMM_NONE = 2'd0;
   localparam logic [1:0] IMM_BYTE = 2'd1;
   localparam logic [1:0] IMM_WORD = 2'd2;
   localparam logic [1:0] IMM_DWORD = 2'd3;
   // Flag image bit positions
   localparam int F_CF = 0;
   localparam int F_PF = 2;
   localparam int F_AF = 4;
   localparam int F_ZF = 6;
   localparam int F_SF = 7;
   localparam int F_TF = 8;
   localparam int F_IF = 9;
   localparam int F_DF = 10;
   localparam int F_OF = 11;
   localparam logic [11:0] FLAGS_WRITABLE = 12'hFD5;
   typedef enum logic [3:0] {
      SPRD_OP_NONE, SPRD_OP_POP_RM, SPRD_OP_POP_REG, SPRD_OP_POP_SEG, SPRD_OP_POP_ALL,
      SPRD_OP_POP_FLAGS, SPRD_OP_PUSH_RM, SPRD_OP_PUSH_REG, SPRD_OP_PUSH_SEG,
      SPRD_OP_PUSH_IMM, SPRD_OP_PUSH_ALL, SPRD_OP_PUSH_FLAGS, SPRD_OP_RCL
   } sprd_op_t;
   typedef struct packed {
      logic valid;
      logic [7:0] data;
   } sprd_byte_t;
   typedef struct packed {
      sprd_op_t op;
      logic lock;
      logic addr32;
      logic opnd32;
      logic [1:0] imm_size;
      logic [3:0] cycles;
   } sprd_issue_t;
endpackage

// *** verification/sprd_decode_monitor.sv ***
// Assertion checker for the stack, prefix and rotate decoder
module sprd_decode_monitor
   import sprd_pkg::*;
(
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire logic prot_mode_i,
   input wire logic ready_o,
   input wire sprd_pkg::sprd_issue_t issue_o,
   input wire logic issue_valid_o,
   input wire logic done_o,
   input wire logic bus_lock_o,
   input wire logic [11:0] flags_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] age;
   logic [3:0] next_age;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!arst_n_i);
   // Execute clock index, so done can be tied to the issued count
   always_comb begin
      next_age = issue_valid_o ? 4'h2 : age + 4'h1;
   end
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         age <= 4'h0;
      end else begin
         age <= next_age;
      end
   end
   a_done_on_count: assert property (
      done_o |-> issue_o.cycles == (issue_valid_o ? 4'h1 : age))
      else $error("done not at issued clock count");
   a_all_six: assert property (
      issue_valid_o && issue_o.op inside {SPRD_OP_POP_ALL, SPRD_OP_PUSH_ALL}
      |-> issue_o.cycles == 4'h6)
      else $error("all-register transfer not six clocks");
   a_pop_flags_nine: assert property (
      issue_valid_o && issue_o.op == SPRD_OP_POP_FLAGS |-> issue_o.cycles == 4'h9)
      else $error("flag pop not nine clocks");
   a_push_flags_two: assert property (
      issue_valid_o && issue_o.op == SPRD_OP_PUSH_FLAGS |-> issue_o.cycles == 4'h2)
      else $error("flag push not two clocks");
   // Mode is sampled when the opcode is taken, two clocks before issue shows
   a_seg_pop_mode: assert property (
      issue_valid_o && issue_o.op == SPRD_OP_POP_SEG
      |-> issue_o.cycles == ($past(prot_mode_i, 2) ? 4'h3 : 4'h1))
      else $error("segment pop count wrong for mode");
   a_single_clock: assert property (
      issue_valid_o && issue_o.op inside {SPRD_OP_POP_RM, SPRD_OP_PUSH_RM, SPRD_OP_PUSH_SEG}
      |-> issue_o.cycles == 4'h1)
      else $error("single clock op not one clock");
   a_rcl_count: assert property (
      issue_valid_o && issue_o.op == SPRD_OP_RCL |-> issue_o.cycles inside {4'h3, 4'h8})
      else $error("rotate count wrong");
   a_flags_kept: assert property (
      issue_valid_o && issue_o.op inside {SPRD_OP_POP_ALL, SPRD_OP_PUSH_ALL,
         SPRD_OP_PUSH_FLAGS, SPRD_OP_PUSH_RM} |=> $stable(flags_o) [*2])
      else $error("flags moved on a flag-neutral op");
   a_lock_follows: assert property (
      issue_valid_o |-> bus_lock_o == issue_o.lock)
      else $error("bus lock differs from prefix");
   a_busy_not_ready: assert property (
      issue_valid_o && !done_o |-> !ready_o)
      else $error("ready high during multi-clock execute");
   a_lock_release: assert property (
      done_o |=> !bus_lock_o)
      else $error("bus lock held past done");
   cover property (issue_valid_o && issue_o.lock);
   cover property (done_o && issue_o.op == SPRD_OP_POP_FLAGS);
   cover property (issue_valid_o && issue_o.op == SPRD_OP_POP_SEG && prot_mode_i);
endmodule
bind sprd_decode sprd_decode_monitor mon_u (.clk_i(clk_i), .arst_n_i(arst_n_i),
   .prot_mode_i(prot_mode_i), .ready_o(ready_o), .issue_o(issue_o),
   .issue_valid_o(issue_valid_o), .done_o(done_o), .bus_lock_o(bus_lock_o), .flags_o(flags_o));

// *** verification/sprd_fetch_model.sv ***
// Fetch path model that hands instruction bytes to the decoder
module sprd_fetch_model
   import sprd_pkg::*;
(
   input wire logic clk_i,
   input wire logic ready_i,
   output sprd_pkg::sprd_byte_t byte_o
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      byte_o = '{valid: 1'b0, data: 8'hA5};
   end
   // Idle data is inverted so a stale byte never looks valid
   task automatic send(input logic [7:0] q[$], input bit slow);
      foreach (q[i]) begin
         if (slow && i > 0) begin
            byte_o <= '{valid: 1'b0, data: ~q[i-1]};
            @(posedge clk_i);
         end
         byte_o <= '{valid: 1'b1, data: q[i]};
         do @(posedge clk_i); while (ready_i !== 1'b1);
      end
      byte_o <= '{valid: 1'b0, data: ~q[q.size()-1]};
   endtask
endmodule

// *** verification/test_stack_prefix_rotate_decode.sv ***
// Self-checking bench for the stack, prefix and rotate decoder
module test_stack_prefix_rotate_decode;
   timeunit 1ns;
   timeprecision 1ps;
   import sprd_pkg::*;
   logic clk_i = 1'b0;
   logic arst_n_i = 1'b0;
   logic prot_mode_i = 1'b0;
   logic default32_i = 1'b0;
   logic [11:0] stack_flags_i = 12'h000;
   logic [7:0] count_register_i = 8'h00;
   sprd_byte_t byte_i;
   sprd_issue_t issue_o;
   logic [11:0] flags_o, keep;
   logic ready_o, issue_valid_o, done_o, bus_lock_o, overflow_undef_o, lk;
   bit slow = 1'b0;
   int n_errors = 0;
   int n_checks = 0;
   always #12.5 clk_i = ~clk_i;
   sprd_decode dut_u (.clk_i(clk_i), .arst_n_i(arst_n_i), .byte_i(byte_i),
      .prot_mode_i(prot_mode_i), .default32_i(default32_i), .stack_flags_i(stack_flags_i),
      .count_register_i(count_register_i), .ready_o(ready_o), .issue_o(issue_o),
      .issue_valid_o(issue_valid_o), .done_o(done_o), .bus_lock_o(bus_lock_o),
      .flags_o(flags_o), .overflow_undef_o(overflow_undef_o));
   sprd_fetch_model fm_u (.clk_i(clk_i), .ready_i(ready_o), .byte_o(byte_i));
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD %s expected %0h seen %0h", what, exp, seen);
      end
   endtask
   task automatic results();
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // One instruction, timed from issue to done; cyc of zero skips timing
   task automatic run(input logic [7:0] q[$], input sprd_op_t op, input logic [3:0] cyc);
      int n;
      fm_u.send(q, slow);
      n = 0;
      do begin
         @(negedge clk_i);
         n++;
      end while (issue_valid_o !== 1'b1 && n < 8);
      lk = bus_lock_o;
      chk("op", {issue_valid_o, 4'(issue_o.op)}, {1'b1, 4'(op)});
      for (n = 1; done_o !== 1'b1 && n < 12; n++) @(negedge clk_i);
      if (cyc != 4'h0) chk("clocks", {issue_o.cycles, 4'(n)}, {cyc, cyc});
      while (ready_o !== 1'b1) @(negedge clk_i);
      @(posedge clk_i);
   endtask
   task automatic t_stack();
      stack_flags_i <= 12'hFFF;
      run('{8'h9D}, SPRD_OP_POP_FLAGS, 4'h9);
      keep = 12'hFFF & FLAGS_WRITABLE;
      chk("popped flags", flags_o, keep);
      run('{8'h9C}, SPRD_OP_PUSH_FLAGS, 4'h2);
      run('{8'h8F, 8'hC0}, SPRD_OP_POP_RM, 4'h1);
      run('{8'hFF, 8'h30}, SPRD_OP_PUSH_RM, 4'h1);
      run('{8'h60}, SPRD_OP_PUSH_ALL, 4'h6);
      run('{8'h61}, SPRD_OP_POP_ALL, 4'h6);
      run('{8'h50}, SPRD_OP_PUSH_REG, 4'h1);
      run('{8'h58}, SPRD_OP_POP_REG, 4'h1);
      chk("kept flags", flags_o, keep);
   endtask
   task automatic t_seg();
      logic [7:0] pops[3] = '{8'h07, 8'h17, 8'h1F};
      for (int m = 0; m < 2; m++) begin
         prot_mode_i <= m[0];
         @(posedge clk_i);
         foreach (pops[i]) run('{pops[i]}, SPRD_OP_POP_SEG, m[0] ? 4'h3 : 4'h1);
         run('{8'h0E}, SPRD_OP_PUSH_SEG, 4'h1);
         run('{8'h0F, 8'hA8}, SPRD_OP_PUSH_SEG, 4'h1);
         run('{8'h0F, 8'hA1}, SPRD_OP_POP_SEG, 4'h0);
      end
   endtask
   task automatic t_prefix();
      slow = 1'b1;
      run('{8'hF0, 8'h8F, 8'hC0}, SPRD_OP_POP_RM, 4'h1);
      chk("lock", {lk, issue_o.lock}, 2'b11);
      run('{8'hF0, 8'h60}, SPRD_OP_PUSH_ALL, 4'h6);
      chk("lock long", lk, 1'b1);
      run('{8'h66, 8'h67, 8'h67, 8'h67, 8'h9C}, SPRD_OP_PUSH_FLAGS, 4'h2);
      chk("sizes", {lk, issue_o.addr32, issue_o.opnd32, flags_o}, {3'b011, keep});
      slow = 1'b0;
   endtask
   task automatic t_rcl();
      count_register_i <= 8'h80;
      run('{8'hD0, 8'hD0}, SPRD_OP_RCL, 4'h3);
      chk("rcl one", {flags_o[F_OF], flags_o[F_CF], overflow_undef_o}, 3'b110);
      count_register_i <= 8'h40;
      run('{8'hD1, 8'h10}, SPRD_OP_RCL, 4'h8);
      chk("rcl mem", {flags_o[F_OF], flags_o[F_CF], overflow_undef_o}, 3'b100);
      run('{8'hD2, 8'hD0}, SPRD_OP_RCL, 4'h8);
      chk("rcl count", {flags_o[F_CF], overflow_undef_o}, 2'b01);
      run('{8'hC0, 8'hD0}, SPRD_OP_RCL, 4'h8);
      chk("rcl imm", {issue_o.imm_size, overflow_undef_o}, {IMM_BYTE, 1'b1});
   endtask
   task automatic t_imm();
      run('{8'h6A}, SPRD_OP_PUSH_IMM, 4'h0);
      chk("imm byte", issue_o.imm_size, IMM_BYTE);
      run('{8'h68}, SPRD_OP_PUSH_IMM, 4'h0);
      chk("imm word", issue_o.imm_size, IMM_WORD);
      // Default size is reloaded as each instruction ends
      default32_i <= 1'b1;
      run('{8'h6A}, SPRD_OP_PUSH_IMM, 4'h0);
      run('{8'h68}, SPRD_OP_PUSH_IMM, 4'h0);
      chk("imm full", issue_o.imm_size, IMM_DWORD);
      run('{8'h66, 8'h68}, SPRD_OP_PUSH_IMM, 4'h0);
      chk("imm toggled", issue_o.imm_size, IMM_WORD);
   endtask
   initial begin
      repeat (8) @(posedge clk_i);
      arst_n_i <= 1'b1;
      @(posedge clk_i);
      t_stack();
      t_seg();
      t_prefix();
      t_rcl();
      t_imm();
      results();
   end
   // Whole run needs well under two thousand clocks
   initial begin
      repeat (5000) @(posedge clk_i);
      n_errors++;
      results();
   end
endmodule
